/* rtl/dapr_pkg.sv */
package dapr_pkg;
   localparam int          DATA_W        = 12;
   localparam int          DATA_MSB      = 11;
   localparam int          CLK_PERIOD_NS = 4;
   // Conversion times, nanoseconds; longest times round down
   localparam int          CONV_HS_NS    = 3600;
   localparam int          CONV_AS_NS    = 6000;
   localparam int          CONV_HS_CYC   = CONV_HS_NS / CLK_PERIOD_NS;
   localparam int          CONV_AS_CYC   = CONV_AS_NS / CLK_PERIOD_NS;
   localparam int          CNT_W         = 12;
   // Bus quiet time a host keeps before each convert start
   localparam int          QUIET_NS      = 300;
   localparam int          QUIET_CYC     = QUIET_NS / CLK_PERIOD_NS;
   localparam logic [11:0] MIDSCALE      = 12'h800;
   localparam logic [11:0] DATA_RST      = 12'h000;
endpackage : dapr_pkg

/* rtl/dapr_code_fmt.sv */
`timescale 1ns/100ps
// Output coding: offset binary sample to twos complement or straight binary
module dapr_code_fmt
   import dapr_pkg::*;
(
   input  wire logic [11:0] raw_i,      // Offset-binary converter code
   input  wire logic        bipolar_i,  // High: twos complement output
   output logic      [11:0] code_o      // Coded result
);
   always_comb begin
      if (bipolar_i) begin
         code_o = raw_i ^ MIDSCALE;
      end else begin
         code_o = raw_i;
      end
   end
endmodule : dapr_code_fmt

/* rtl/dapr_top.sv */
// Function
// - Twelve-bit result bus, bit 11 MSB, released unless read enabled.
// - Bipolar variants output twos complement codes.
// - Unipolar variant outputs straight binary codes.
// - Convert-start falling edge while idle holds both channels and starts both converters.
// - Busy rises on convert-start fall, falls when both conversions finish.
// - Data driven only while read strobe and chip select both low.
// - Pair-select low: first read input one of A, next input two of A.
// - Pair-select high: first read input one of B, next input two of B.
// - Read strobes without chip select leave the bus untouched.
// - Conversion ends within 3.6 us, or 6 us in auto sleep.
`timescale 1ns/100ps
module dapr_top
   import dapr_pkg::*;
(
   input  wire logic        clk_i,             // 250 MHz clock
   input  wire logic        rstn_i,            // Async reset, active low
   input  wire logic        en_i,              // Clock enable
   input  wire logic        convert_start_n,   // Convert start, active low
   input  wire logic        cs_n_i,            // Chip select, active low
   input  wire logic        rd_n_i,            // Read strobe, active low
   input  wire logic        pair_select,       // Low pair A, high pair B
   input  wire logic        bipolar_i,         // Bipolar range variant
   input  wire logic        auto_sleep_i,      // Auto sleep mode
   input  wire logic [11:0] pair_a_input_one,  // Sampled code, A input 1
   input  wire logic [11:0] pair_a_input_two,  // Sampled code, A input 2
   input  wire logic [11:0] pair_b_input_one,  // Sampled code, B input 1
   input  wire logic [11:0] pair_b_input_two,  // Sampled code, B input 2
   output logic      [11:0] data_o,            // Result bus value
   output logic      [11:0] data_oe_o,         // Result bus enables
   output logic             busy_o,            // Conversion in progress
   output logic             hold_o             // Track/holds in hold
);
   typedef enum logic [0:0] {DAPR_IDLE, DAPR_CONV} dapr_state_t;

   dapr_state_t      state;
   dapr_state_t      next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             cst_q;
   logic             next_cst_q;
   logic             rd_q;
   logic             next_rd_q;
   logic             ptr;
   logic             next_ptr;
   logic [11:0]      hold_mem [0:3];
   logic [11:0]      next_hold_mem [0:3];
   logic [11:0]      data;
   logic [11:0]      next_data;
   logic [11:0]      sel_raw;
   logic [11:0]      fmt_code;
   logic             start;
   logic             read_en;
   logic             rd_end;
   logic [CNT_W-1:0] conv_len;

   function automatic logic [1:0] dapr_slot(input logic pair,
                                            input logic second);
      dapr_slot = {pair, second};
   endfunction : dapr_slot

   ////////////////////////////////////////////////////////////////////////
   // Convert-start edge sampler
   // Resets high, so a start held low through reset is taken as an edge
   always_comb begin
      next_cst_q = convert_start_n;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cst_q <= 1'b1;
      end else if (en_i) begin
         cst_q <= next_cst_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion control
   // Edges during a conversion are refused and must not touch the pointer
   assign start    = cst_q && !convert_start_n
                     && (state == DAPR_IDLE);
   assign conv_len = auto_sleep_i ? CNT_W'(CONV_AS_CYC)
                                  : CNT_W'(CONV_HS_CYC);

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         DAPR_IDLE: begin
            if (start) begin
               next_state = DAPR_CONV;
               next_cnt   = conv_len - CNT_W'(1);
            end
         end
         DAPR_CONV: begin
            if (cnt == '0) begin
               next_state = DAPR_IDLE;
            end else begin
               next_cnt = cnt - CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= DAPR_IDLE;
         cnt   <= '0;
      end else if (en_i) begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   assign busy_o = (state == DAPR_CONV);
   assign hold_o = (state == DAPR_CONV);

   ////////////////////////////////////////////////////////////////////////
   // Held samples
   // All four codes taken on one edge to keep their relative phase.
   // Limitation: a read during busy already sees the new codes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_hold_mem[i] = hold_mem[i];
      end
      if (start) begin
         next_hold_mem[0] = pair_a_input_one;
         next_hold_mem[1] = pair_a_input_two;
         next_hold_mem[2] = pair_b_input_one;
         next_hold_mem[3] = pair_b_input_two;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 4; i++) begin
            hold_mem[i] <= DATA_RST;
         end
      end else if (en_i) begin
         hold_mem <= next_hold_mem;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read sequencing
   // Selection needs both strobes; the pointer is gated by both strobes too
   assign read_en = !cs_n_i && !rd_n_i;
   // Pointer advances on the trailing end of each selected read
   assign rd_end  = rd_q && !read_en;

   assign sel_raw = hold_mem[dapr_slot(pair_select, ptr)];

   dapr_code_fmt u_fmt (
      .raw_i     (sel_raw),
      .bipolar_i (bipolar_i),
      .code_o    (fmt_code)
   );

   always_comb begin
      next_rd_q = read_en;
      next_ptr  = ptr;
      next_data = data;
      if (start) begin
         next_ptr = 1'b0;
      end else if (rd_end) begin
         next_ptr = !ptr;
      end
      if (read_en) begin
         next_data = fmt_code;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_q <= 1'b0;
         ptr  <= 1'b0;
         data <= DATA_RST;
      end else if (en_i) begin
         rd_q <= next_rd_q;
         ptr  <= next_ptr;
         data <= next_data;
      end
   end

   // Enables rise one cycle after the strobe and drop with it, so data is stable when driven
   assign data_o    = data;
   assign data_oe_o = {DATA_W{rd_q && read_en}};
endmodule : dapr_top

/* tb/dapr_host.sv */
`timescale 1ns/100ps
module dapr_host
   import dapr_pkg::*;
(
   input  wire logic clk_i,    // Clock
   input  wire logic busy_i,   // Busy
   output logic      conv_n_o, // Start
   output logic      cs_n_o,   // Select
   output logic      rd_n_o,   // Read
   output logic      psel_o    // Pair
);
   initial {conv_n_o, cs_n_o, rd_n_o, psel_o} = 4'he;
   // Reads wait for busy low, so no read overlaps a conversion
   task automatic conv(output int n);
      n = 0;
      // Bus quiet before the sampling edge keeps full accuracy
      repeat (QUIET_CYC) @(negedge clk_i);
      @(negedge clk_i) conv_n_o = 1'b0;
      @(negedge clk_i) conv_n_o = 1'b1;
      while (busy_i && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
   endtask : conv
   task automatic rd(input logic cs, input logic ps);
      @(negedge clk_i) {cs_n_o, rd_n_o, psel_o} = {cs, 1'b0, ps};
      repeat (2) @(negedge clk_i);
      {cs_n_o, rd_n_o} = 2'h3;
   endtask : rd
endmodule : dapr_host

/* tb/dapr_top_assertions.sv */
`timescale 1ns/100ps
module dapr_top_assertions
   import dapr_pkg::*;
(
   input wire logic        clk_i,           // Clock
   input wire logic        en_i,            // Clock enable
   input wire logic        rstn_i,          // Reset
   input wire logic        convert_start_n, // Start
   input wire logic        cs_n_i,          // Select
   input wire logic        rd_n_i,          // Read
   input wire logic        auto_sleep_i,    // Mode
   input wire logic [11:0] data_oe_o,       // Enables
   input wire logic        busy_o,          // Busy
   input wire logic        hold_o           // Hold
);
   logic [11:0] cnt;
   logic        md;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 12'h000;
         md  <= 1'b0;
      end else if (en_i) begin
         // Frozen cycles do not count towards the conversion length
         cnt <= busy_o ? cnt + 12'h001 : 12'h000;
         md  <= busy_o ? md : auto_sleep_i;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_start;
      $fell(convert_start_n) ##0 !busy_o ##0 en_i;
   endsequence
   sequence s_read; !cs_n_i && !rd_n_i; endsequence
   a_oe_needs_strobes: assert property (data_oe_o != 0 |-> s_read)
      else $error("bus driven without strobes");
   a_oe_all_bits: assert property (data_oe_o == 0 || &data_oe_o)
      else $error("bus enables split");
   a_cs_gates_bus: assert property (cs_n_i |-> data_oe_o == 0)
      else $error("bus driven while deselected");
   a_read_drives: assert property (s_read ##1 s_read |-> &data_oe_o)
      else $error("bus not driven in read");
   a_busy_on_start: assert property (s_start |=> busy_o)
      else $error("busy missing after start");
   a_hold_with_busy: assert property (hold_o == busy_o)
      else $error("hold differs from busy");
   a_busy_length: assert property ($fell(busy_o) |->
      cnt == (md ? 12'(CONV_AS_CYC) : 12'(CONV_HS_CYC)))
      else $error("busy length wrong");
   a_busy_bounded: assert property (cnt <= 12'(CONV_AS_CYC))
      else $error("conversion too long");
endmodule : dapr_top_assertions
bind dapr_top dapr_top_assertions chk (.clk_i(clk_i), .rstn_i(rstn_i),
   .en_i(en_i), .convert_start_n(convert_start_n), .cs_n_i(cs_n_i),
   .rd_n_i(rd_n_i), .auto_sleep_i(auto_sleep_i), .data_oe_o(data_oe_o),
   .busy_o(busy_o), .hold_o(hold_o));

/* tb/tb_dapr_top.sv */
`timescale 1ns/100ps
module tb_dapr_top;
   import dapr_pkg::*;
   logic        clk_i = 1'b0, rstn_i = 1'b0, bip, slp, cv, cs, rd, ps;
   logic        busy_o, hold_o, was = 1'b0, ptr, p, frz, en = 1'b1;
   logic [11:0] in [4], cap [4], data_o, data_oe_o, expq [$];
   int          num_errors = 0, comparisons = 0, seed = 32'hf7b8, n, cyc = 0;
   int          xn;
   // Freeze lands well inside the shortest conversion
   localparam int FRZ_AT = QUIET_CYC + 100, FRZ_LEN = 8;
   initial forever #2 clk_i = ~clk_i;
   dapr_host host (.clk_i(clk_i), .busy_i(busy_o), .conv_n_o(cv),
      .cs_n_o(cs), .rd_n_o(rd), .psel_o(ps));
   dapr_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en),
      .convert_start_n(cv), .cs_n_i(cs), .rd_n_i(rd), .pair_select(ps),
      .bipolar_i(bip), .auto_sleep_i(slp), .pair_a_input_one(in[0]),
      .pair_a_input_two(in[1]), .pair_b_input_one(in[2]),
      .pair_b_input_two(in[3]), .data_o(data_o), .data_oe_o(data_oe_o),
      .busy_o(busy_o), .hold_o(hold_o));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task end_of_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // Sampled off the launching edge so data and enables have settled
   always @(negedge clk_i) begin
      if (data_oe_o === 12'hfff && !was) begin
         if (expq.size() == 0) begin
            num_errors++;
            $display("unexpected drive at %0t got %h exp %h", $time,
                     data_o, 12'h000);
         end else begin
            chk(data_o, expq.pop_front());
         end
      end
      was <= (data_oe_o === 12'hfff);
      if (++cyc == 30000) begin
         num_errors++;
         end_of_test;
      end
   end
   initial begin
      {bip, slp} = 2'h0;
      in = '{default: 12'h000};
      repeat (20) @(negedge clk_i);
      rstn_i = 1'b1;
      for (int k = 0; k < 6; k++) begin
         @(negedge clk_i) {bip, slp} = 2'($random(seed));
         foreach (in[i]) in[i] = 12'($random(seed));
         cap = in;
         // Every other conversion is frozen by the clock enable for a while
         frz = k[0];
         fork
            host.conv(n);
            if (frz) begin
               repeat (FRZ_AT) @(negedge clk_i);
               en = 1'b0;
               repeat (FRZ_LEN) @(negedge clk_i);
               en = 1'b1;
            end
         join
         xn = (slp ? CONV_AS_CYC : CONV_HS_CYC) + (frz ? FRZ_LEN : 0);
         chk(12'(n), 12'(xn));
         // New codes after start must not reach the results
         foreach (in[i]) in[i] = 12'($random(seed));
         ptr = 1'b0;
         repeat (3) begin
            p = 1'($random(seed));
            expq.push_back(cap[{p, ptr}] ^ (bip ? MIDSCALE : 12'h000));
            host.rd(1'b0, p);
            ptr = ~ptr;
         end
         host.rd(1'b1, 1'b0);
      end
      repeat (4) @(negedge clk_i);
      chk(12'(expq.size()), 12'h000);
      end_of_test;
   end
endmodule : tb_dapr_top
